/* src/pfs_pad_mux.sv */
// Purpose: Pad function select and low-power pad state control.
// Assumes: Register port with one-cycle read latency; mode inputs from power control.
// Notes:   Pad 6 is oscillator enable / boot sense, pad 7 is the slow crystal negative pad.
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
// Operation
// - Pads come up on default function; code zero selects GPIO.
// - Deep sleep puts pads Hi-Z unless software programs pull or drive.
// - Hibernate puts pads other than oscillator enable Hi-Z unless software programs pull or drive.
// - Oscillator enable pad is an output driven high from power-up.
// - In hibernate oscillator enable pad goes Hi-Z with pull-down.
// - Pull-up sensed on slow crystal negative pad frees it for digital use.
// - Audio data on slow crystal negative pad is output only.
// - Debug pads default to JTAG/SWD functions after reset.
module pfs_pad_mux
    import pfs_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic [PFS_AW-1:0]     addr,
    input  wire logic [31:0]           wdata,
    input  wire logic                  wr,
    input  wire logic                  rd,
    output logic      [31:0]           rdata,
    input  wire logic                  deep_sleep_state,
    input  wire logic                  hibernate_state,
    input  wire logic [PFS_NPADS-1:0]  gpio_out,
    input  wire logic [PFS_NPADS-1:0]  gpio_oe,
    output logic      [PFS_NPADS-1:0]  gpio_in,
    input  wire logic [PFS_NPADS-1:0]  periph_out,
    input  wire logic [PFS_NPADS-1:0]  periph_oe,
    output logic      [PFS_NPADS-1:0]  periph_in,
    input  wire logic                  debug_tdo,
    output logic                       debug_tdi,
    output logic                       debug_tck,
    output logic                       debug_tms,
    input  wire logic                  audio_serial_data0,
    input  wire logic [PFS_NPADS-1:0]  pad_i,
    output logic      [PFS_NPADS-1:0]  pad_o,
    output logic      [PFS_NPADS-1:0]  pad_oe,
    output logic      [PFS_NPADS-1:0]  pad_pull,
    output logic                       pad_pull_dn,
    output logic                       ext_oscillator_enable,
    output logic                       boot_mode_sense_2,
    output logic                       slow_ext_clock
);
    logic [PFS_FW-1:0] func     [PFS_NPADS];
    logic [1:0]        lp_cfg   [PFS_NPADS];
    logic [PFS_FW-1:0] next_func   [PFS_NPADS];
    logic [1:0]        next_lp_cfg [PFS_NPADS];
    logic              osc_en;
    logic              next_osc_en;
    logic [31:0]       next_rdata;
    logic [PFS_NPADS-1:0] pad_sync;
    logic [PFS_NPADS-1:0] act_o;
    logic [PFS_NPADS-1:0] act_oe;
    logic [PFS_NPADS-1:0] act_pull;
    logic [PFS_NPADS-1:0] cell_o;
    logic [PFS_NPADS-1:0] cell_oe;
    logic [PFS_NPADS-1:0] cell_pull;
    pfs_mode_t         mode;
    pfs_mode_t         next_mode;
    logic [7:0]        sense_cnt;
    logic [7:0]        next_sense_cnt;
    logic              sense_done;
    logic              next_sense_done;
    logic              slow_ext;
    logic              next_slow_ext;
    logic              boot_sense;
    logic              next_boot_sense;

    // Power mode tracking; hibernate takes priority over deep sleep.
    always_comb begin
        if (hibernate_state) begin
            next_mode = PFS_ST_HIB;
        end else if (deep_sleep_state) begin
            next_mode = PFS_ST_DEEP;
        end else begin
            next_mode = PFS_ST_ACTIVE;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode <= PFS_ST_ACTIVE;
        end else begin
            mode <= next_mode;
        end
    end

    // Register writes; a write takes effect on the next edge.
    always_comb begin
        for (int i = 0; i < PFS_NPADS; i++) begin
            next_func[i]   = func[i];
            next_lp_cfg[i] = lp_cfg[i];
            if (wr && addr == PFS_AW'(PFS_PAD_BASE + 8'(4 * i))) begin
                next_func[i]   = wdata[PFS_F_FUNC_LSB +: PFS_FW];
                next_lp_cfg[i] = wdata[PFS_F_LP_LSB +: 2];
            end
        end
        next_osc_en = osc_en;
        if (wr && addr == PFS_CTRL_OFF) begin
            next_osc_en = wdata[0];
        end
    end

    // Debug pads reset to the debug function, the rest to GPIO.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < PFS_NPADS; i++) begin
                if (i >= PFS_PAD_TDI && i <= PFS_PAD_TMS) begin
                    func[i] <= PFS_RST_DBG[PFS_FW-1:0];
                end else begin
                    func[i] <= PFS_RST_PAD[PFS_FW-1:0];
                end
                lp_cfg[i] <= PFS_LP_HIZ;
            end
            osc_en <= 1'b1;
        end else begin
            for (int i = 0; i < PFS_NPADS; i++) begin
                func[i]   <= next_func[i];
                lp_cfg[i] <= next_lp_cfg[i];
            end
            osc_en <= next_osc_en;
        end
    end

    // Read path: data stand in the cycle after the strobe only.
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (rd) begin
            for (int i = 0; i < PFS_NPADS; i++) begin
                if (addr == PFS_AW'(PFS_PAD_BASE + 8'(4 * i))) begin
                    next_rdata = {26'h000_0000, lp_cfg[i], func[i]};
                end
            end
            if (addr == PFS_CTRL_OFF) begin
                next_rdata = {31'h0000_0000, osc_en};
            end
            if (addr == PFS_STAT_OFF) begin
                next_rdata = {27'h000_0000, mode, boot_sense, slow_ext};
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 32'h0000_0000;
        end else begin
            rdata <= next_rdata;
        end
    end

    // Boot and slow clock sensing: sample strapped levels once after reset settles.
    always_comb begin
        next_sense_cnt  = sense_cnt;
        next_sense_done = sense_done;
        next_slow_ext   = slow_ext;
        next_boot_sense = boot_sense;
        if (!sense_done) begin
            if (sense_cnt == 8'(PFS_SENSE_CYCLES - 1)) begin
                next_sense_done = 1'b1;
                next_slow_ext   = pad_sync[PFS_PAD_SLOWNEG];
                next_boot_sense = pad_sync[PFS_PAD_OSC];
            end else begin
                next_sense_cnt = sense_cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sense_cnt  <= 8'h00;
            sense_done <= 1'b0;
            slow_ext   <= 1'b0;
            boot_sense <= 1'b0;
        end else begin
            sense_cnt  <= next_sense_cnt;
            sense_done <= next_sense_done;
            slow_ext   <= next_slow_ext;
            boot_sense <= next_boot_sense;
        end
    end

    // Active routing per pad.
    genvar g;
    generate
        for (g = 0; g < PFS_NPADS; g++) begin : gen_pad
            pfs_sync3 u_sync (
                .clk   (clk),
                .rst_n (rst_n),
                .din   (pad_i[g]),
                .dout  (pad_sync[g])
            );

            always_comb begin
                act_pull[g] = 1'b0;
                if (g == PFS_PAD_OSC) begin
                    // Oscillator enable pad is output only.
                    act_o[g]  = osc_en;
                    act_oe[g] = 1'b1;
                end else if (g == PFS_PAD_SLOWNEG && !slow_ext) begin
                    // Pad still owned by the crystal.
                    act_o[g]  = 1'b0;
                    act_oe[g] = 1'b0;
                end else if (func[g] == PFS_FN_GPIO) begin
                    act_o[g]  = gpio_out[g];
                    act_oe[g] = gpio_oe[g];
                end else if (func[g] == PFS_FN_DEBUG && g == PFS_PAD_TDO) begin
                    act_o[g]  = debug_tdo;
                    act_oe[g] = 1'b1;
                end else if (func[g] == PFS_FN_AUDIO && g == PFS_PAD_SLOWNEG) begin
                    act_o[g]  = audio_serial_data0;
                    act_oe[g] = 1'b1;
                end else if (func[g] == PFS_FN_PERIPH_MAX) begin
                    act_o[g]  = periph_out[g];
                    act_oe[g] = periph_oe[g];
                end else begin
                    act_o[g]  = 1'b0;
                    act_oe[g] = 1'b0;
                end
            end

            pfs_pad_cell u_cell (
                .low_power (mode != PFS_ST_ACTIVE),
                .lp_state  (lp_cfg[g]),
                .act_o     (act_o[g]),
                .act_oe    (act_oe[g]),
                .act_pull  (act_pull[g]),
                .pad_o     (cell_o[g]),
                .pad_oe    (cell_oe[g]),
                .pad_pull  (cell_pull[g])
            );

            assign gpio_in[g]   = (func[g] == PFS_FN_GPIO) ? pad_sync[g] : 1'b0;
            // Audio data on the slow crystal pad never feeds back as a receive input.
            assign periph_in[g] = (func[g] == PFS_FN_PERIPH_MAX) ? pad_sync[g] : 1'b0;
        end
    endgenerate

    // Oscillator pad overrides the cell in hibernate: released with pull-down.
    always_comb begin
        pad_o    = cell_o;
        pad_oe   = cell_oe;
        pad_pull = cell_pull;
        if (mode == PFS_ST_HIB) begin
            pad_o[PFS_PAD_OSC]    = 1'b0;
            pad_oe[PFS_PAD_OSC]   = 1'b0;
            pad_pull[PFS_PAD_OSC] = 1'b0;
        end
    end

    assign pad_pull_dn           = (mode == PFS_ST_HIB);
    assign ext_oscillator_enable = pad_oe[PFS_PAD_OSC] & pad_o[PFS_PAD_OSC];
    assign boot_mode_sense_2     = boot_sense;
    assign slow_ext_clock        = slow_ext;
    assign debug_tdi = (func[PFS_PAD_TDI] == PFS_FN_DEBUG) ? pad_sync[PFS_PAD_TDI] : 1'b0;
    assign debug_tck = (func[PFS_PAD_TCK] == PFS_FN_DEBUG) ? pad_sync[PFS_PAD_TCK] : 1'b0;
    assign debug_tms = (func[PFS_PAD_TMS] == PFS_FN_DEBUG) ? pad_sync[PFS_PAD_TMS] : 1'b0;

    osc_reset_high_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(rst_n) |-> ext_oscillator_enable)
        else $error("oscillator enable not high after reset");
    osc_hib_hiz_a: assert property (@(posedge clk) disable iff (!rst_n)
        mode == PFS_ST_HIB |-> !pad_oe[PFS_PAD_OSC] && pad_pull_dn)
        else $error("oscillator pad driven in hibernate");
    osc_out_only_a: assert property (@(posedge clk) disable iff (!rst_n)
        mode == PFS_ST_ACTIVE |-> pad_oe[PFS_PAD_OSC])
        else $error("oscillator pad not output when active");
    deep_hiz_a: assert property (@(posedge clk) disable iff (!rst_n)
        mode == PFS_ST_DEEP && lp_cfg[0] == PFS_LP_HIZ |-> !pad_oe[0] && !pad_pull[0])
        else $error("deep sleep pad not high impedance");
    hib_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
        mode == PFS_ST_HIB && lp_cfg[0] == PFS_LP_DRV1 |-> pad_oe[0] && pad_o[0])
        else $error("hibernate drive level not applied");
    func_apply_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr && addr == PFS_PAD_BASE |=> func[0] == $past(wdata[3:0]))
        else $error("function write not applied");
    unassigned_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        mode == PFS_ST_ACTIVE && func[1] == 4'hF |-> !pad_oe[1] && !periph_in[1])
        else $error("unassigned code still connected");
    slow_neg_held_a: assert property (@(posedge clk) disable iff (!rst_n)
        mode == PFS_ST_ACTIVE && !slow_ext |-> !pad_oe[PFS_PAD_SLOWNEG])
        else $error("slow crystal pad driven without sensing");
    audio_out_only_a: assert property (@(posedge clk) disable iff (!rst_n)
        func[PFS_PAD_SLOWNEG] == PFS_FN_AUDIO |-> !periph_in[PFS_PAD_SLOWNEG])
        else $error("audio data fed back from slow crystal pad");
    debug_default_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(rst_n) |-> func[PFS_PAD_TCK] == PFS_FN_DEBUG)
        else $error("debug pad not on debug function after reset");
    gpio_route_a: assert property (@(posedge clk) disable iff (!rst_n)
        mode == PFS_ST_ACTIVE && func[0] == PFS_FN_GPIO |-> pad_oe[0] == gpio_oe[0])
        else $error("gpio not routed for code zero");
    tdo_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
        mode == PFS_ST_ACTIVE && func[PFS_PAD_TDO] == PFS_FN_DEBUG
            |-> pad_oe[PFS_PAD_TDO] && pad_o[PFS_PAD_TDO] == debug_tdo)
        else $error("debug data out pad not driven");
    audio_no_gpio_a: assert property (@(posedge clk) disable iff (!rst_n)
        func[PFS_PAD_SLOWNEG] == PFS_FN_AUDIO |-> !gpio_in[PFS_PAD_SLOWNEG])
        else $error("audio pad seen as gpio input");
    deep_pull_a: assert property (@(posedge clk) disable iff (!rst_n)
        mode == PFS_ST_DEEP && lp_cfg[1] == PFS_LP_PULL |-> pad_pull[1] && !pad_oe[1])
        else $error("deep sleep pull not applied");
endmodule

/* src/pfs_pkg.sv */
// Purpose: Shared constants for the pad function select and low-power pad state block.
// Assumes: 200 MHz clk; simple register port with one-cycle read latency.
// Notes:   One 32-bit register per pad; offsets are byte addresses.
package pfs_pkg;
    localparam int unsigned PFS_NPADS = 8;
    localparam int unsigned PFS_AW    = 8;
    localparam int unsigned PFS_FW    = 4;

    // Pad indices.
    localparam int unsigned PFS_PAD_GPIO_A  = 0;
    localparam int unsigned PFS_PAD_GPIO_B  = 1;
    localparam int unsigned PFS_PAD_TDI     = 2;
    localparam int unsigned PFS_PAD_TDO     = 3;
    localparam int unsigned PFS_PAD_TCK     = 4;
    localparam int unsigned PFS_PAD_TMS     = 5;
    localparam int unsigned PFS_PAD_OSC     = 6;
    localparam int unsigned PFS_PAD_SLOWNEG = 7;

    // Register map: pad n config at PFS_PAD_BASE + 4*n, then control and status.
    localparam logic [7:0] PFS_PAD_BASE  = 8'h00;
    localparam logic [7:0] PFS_CTRL_OFF  = 8'h20;
    localparam logic [7:0] PFS_STAT_OFF  = 8'h24;

    // Pad config field positions.
    localparam int unsigned PFS_F_FUNC_LSB = 0;
    localparam int unsigned PFS_F_LP_LSB   = 4;
    // Function codes.
    localparam logic [3:0] PFS_FN_GPIO  = 4'h0;
    localparam logic [3:0] PFS_FN_DEBUG = 4'h1;
    localparam logic [3:0] PFS_FN_AUDIO = 4'h4;
    localparam logic [3:0] PFS_FN_PERIPH_MAX = 4'h2;
    // Low-power pad state codes.
    localparam logic [1:0] PFS_LP_HIZ   = 2'h0;
    localparam logic [1:0] PFS_LP_PULL  = 2'h1;
    localparam logic [1:0] PFS_LP_DRV0  = 2'h2;
    localparam logic [1:0] PFS_LP_DRV1  = 2'h3;

    // Reset values.
    localparam logic [31:0] PFS_RST_PAD = 32'h0000_0000;
    localparam logic [31:0] PFS_RST_DBG = 32'h0000_0001;
    localparam logic [31:0] PFS_RST_CTRL = 32'h0000_0000;

    // Slow clock pad sensing settle time after reset.
    localparam int unsigned PFS_SENSE_NS     = 100;
    localparam int unsigned PFS_CLK_NS       = 5;
    localparam int unsigned PFS_SENSE_CYCLES = (PFS_SENSE_NS + PFS_CLK_NS - 1) / PFS_CLK_NS;

    typedef enum logic [2:0] {
        PFS_ST_ACTIVE = 3'b001,
        PFS_ST_DEEP   = 3'b010,
        PFS_ST_HIB    = 3'b100
    } pfs_mode_t;
endpackage

/* src/pfs_sync3.sv */
// Purpose: Three-stage synchroniser with agreement filter for a pad input.
// Assumes: Input is asynchronous to clk.
// Notes:   Output changes once stages two and three agree.
`timescale 1ns/1ps
module pfs_sync3 (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic din,
    output logic      dout
);
    logic s1;
    logic s2;
    logic s3;
    logic next_dout;

    always_comb begin
        next_dout = (s2 == s3) ? s3 : dout;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1   <= 1'b0;
            s2   <= 1'b0;
            s3   <= 1'b0;
            dout <= 1'b0;
        end else begin
            s1   <= din;
            s2   <= s1;
            s3   <= s2;
            dout <= next_dout;
        end
    end
endmodule

/* src/pfs_pad_cell.sv */
// Purpose: One pad's output stage: active routing or low-power retained state.
// Assumes: Function already resolved to output, enable and pull.
// Notes:   Low-power state overrides the active selection completely.
`timescale 1ns/1ps
module pfs_pad_cell
    import pfs_pkg::*;
(
    input  wire logic       low_power,
    input  wire logic [1:0] lp_state,
    input  wire logic       act_o,
    input  wire logic       act_oe,
    input  wire logic       act_pull,
    output logic            pad_o,
    output logic            pad_oe,
    output logic            pad_pull
);
    always_comb begin
        if (low_power) begin
            pad_o    = (lp_state == PFS_LP_DRV1);
            pad_oe   = lp_state[1];
            pad_pull = (lp_state == PFS_LP_PULL);
        end else begin
            pad_o    = act_o;
            pad_oe   = act_oe;
            pad_pull = act_pull;
        end
    end
endmodule

/* bench/tb_top.sv */
// Purpose: Self-checking bench for the pad function select and low-power pad state block.
// Assumes: 200 MHz clk; register port strobes are one cycle; pad inputs settle within 4 edges.
// Notes:   Drivers queue each expected result; a watcher compares when the result appears.
`timescale 1ns/1ps
module tb_top
    import pfs_pkg::*;
();
    typedef struct {
        logic        is_read;
        logic [63:0] mask;
        logic [63:0] val;
    } pfs_note_t;

    logic                 clk;
    logic                 rst_n;
    logic [PFS_AW-1:0]    addr;
    logic [31:0]          wdata;
    logic                 wr;
    logic                 rd;
    logic [31:0]          rdata;
    logic                 deep_sleep_state;
    logic                 hibernate_state;
    logic [PFS_NPADS-1:0] gpio_out;
    logic [PFS_NPADS-1:0] gpio_oe;
    logic [PFS_NPADS-1:0] gpio_in;
    logic [PFS_NPADS-1:0] periph_out;
    logic [PFS_NPADS-1:0] periph_oe;
    logic [PFS_NPADS-1:0] periph_in;
    logic                 debug_tdo;
    logic                 debug_tdi;
    logic                 debug_tck;
    logic                 debug_tms;
    logic                 audio_serial_data0;
    logic [PFS_NPADS-1:0] pad_i;
    logic [PFS_NPADS-1:0] pad_o;
    logic [PFS_NPADS-1:0] pad_oe;
    logic [PFS_NPADS-1:0] pad_pull;
    logic                 pad_pull_dn;
    logic                 ext_oscillator_enable;
    logic                 boot_mode_sense_2;
    logic                 slow_ext_clock;
    logic                 probe;
    logic                 rd_q;
    logic [63:0]          obs;
    logic [31:0]          rv;
    int                   seed;
    int                   fails;
    int                   n_compared;
    pfs_note_t            notes[$];
    pfs_note_t            note;

    // Bit map of everything a probe can look at: o 0+n, oe 8+n, pull 16+n, gpio_in 24+n,
    // periph_in 32+n, pull-down 40, osc enable 41, boot 42, slow clock 43, tdi 44, tck 45, tms 46.
    assign obs = {17'h0, debug_tms, debug_tck, debug_tdi, slow_ext_clock, boot_mode_sense_2,
                  ext_oscillator_enable, pad_pull_dn, periph_in, gpio_in, pad_pull, pad_oe, pad_o};

    pfs_pad_mux i_pfs_pad_mux (
        .clk                   (clk),
        .rst_n                 (rst_n),
        .addr                  (addr),
        .wdata                 (wdata),
        .wr                    (wr),
        .rd                    (rd),
        .rdata                 (rdata),
        .deep_sleep_state      (deep_sleep_state),
        .hibernate_state       (hibernate_state),
        .gpio_out              (gpio_out),
        .gpio_oe               (gpio_oe),
        .gpio_in               (gpio_in),
        .periph_out            (periph_out),
        .periph_oe             (periph_oe),
        .periph_in             (periph_in),
        .debug_tdo             (debug_tdo),
        .debug_tdi             (debug_tdi),
        .debug_tck             (debug_tck),
        .debug_tms             (debug_tms),
        .audio_serial_data0    (audio_serial_data0),
        .pad_i                 (pad_i),
        .pad_o                 (pad_o),
        .pad_oe                (pad_oe),
        .pad_pull              (pad_pull),
        .pad_pull_dn           (pad_pull_dn),
        .ext_oscillator_enable (ext_oscillator_enable),
        .boot_mode_sense_2     (boot_mode_sense_2),
        .slow_ext_clock        (slow_ext_clock)
    );

    initial clk = 1'b0;
    always #2.5 clk = ~clk;

    function automatic logic [63:0] fld(input int p, input logic b);
        fld = 64'(b) << p;
    endfunction

    function automatic logic [7:0] pad_addr(input int n);
        pad_addr = PFS_PAD_BASE + 8'(4 * n);
    endfunction

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // The extra edge keeps a following strobe from landing in the same time step.
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
        notes.push_back('{1'b1, 64'hFFFF_FFFF, {32'h0, e}});
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
    endtask

    task automatic expect_obs(input logic [63:0] m, input logic [63:0] v);
        notes.push_back('{1'b0, m, v & m});
        probe <= 1'b1;
        @(posedge clk);
        probe <= 1'b0;
        @(posedge clk);
    endtask

    // Read data stand only in the cycle after the strobe, so they are taken at its closing edge.
    always @(posedge clk) begin
        rd_q <= rd;
        if (rd_q || probe) begin
            if (notes.size() == 0) begin
                fails++;
                $display("mismatch at %0t: seen %h expected %h", $time, obs, 64'h0);
            end else begin
                note = notes.pop_front();
                check(note.is_read ? {32'h0, rdata} : (obs & note.mask), note.val);
            end
        end
    end

    initial begin
        #(40000 * 5);
        fails++;
        $display("watchdog expired");
        tally_and_finish();
    end

    initial begin
        int          i;
        int          lp;
        int          md;
        int          codes[5];
        logic [3:0]  c;
        logic [63:0] m;
        logic [63:0] v;
        codes = '{0, 2, 3, 5, 15};
        seed = 33;
        fails = 0;
        n_compared = 0;
        rst_n = 1'b0;
        {wr, rd, probe} = 3'h0;
        addr = 8'h00;
        wdata = 32'h0000_0000;
        {deep_sleep_state, hibernate_state} = 2'b00;
        {gpio_out, gpio_oe, periph_out, periph_oe} = 32'h0000_0000;
        debug_tdo = 1'b1;
        audio_serial_data0 = 1'b0;
        // Pull-up on the slow crystal pad, boot strap high, tdi and tms high.
        pad_i = 8'hE4;
        tick(6);
        rst_n <= 1'b1;
        @(posedge clk);
        expect_obs(fld(41, 1) | fld(6, 1) | fld(14, 1), fld(41, 1) | fld(6, 1) | fld(14, 1));
        tick(25);
        for (i = 0; i < 8; i++) begin
            reg_rd(pad_addr(i), (i >= 2 && i <= 5) ? PFS_RST_DBG : PFS_RST_PAD);
        end
        m = fld(44, 1) | fld(45, 1) | fld(46, 1) | fld(3, 1) | fld(11, 1) | fld(10, 1);
        expect_obs(m, fld(44, 1) | fld(46, 1) | fld(3, 1) | fld(11, 1));
        debug_tdo <= 1'b0;
        expect_obs(fld(3, 1), 64'h0);
        expect_obs(fld(42, 1) | fld(43, 1), fld(42, 1) | fld(43, 1));
        reg_rd(PFS_STAT_OFF, 32'h0000_0007);
        reg_wr(8'h40, 32'hFFFF_FFFF);
        reg_rd(8'h40, 32'h0000_0000);
        reg_rd(8'h28, 32'h0000_0000);
        reg_wr(pad_addr(1), 32'h0000_0035);
        reg_rd(pad_addr(1), 32'h0000_0035);
        // Both sources drive opposite levels, so the selected one shows at the pad.
        gpio_oe <= 8'hFF;
        periph_oe <= 8'hFF;
        periph_out <= 8'hFF;
        pad_i[1] <= 1'b1;
        tick(4);
        foreach (codes[k]) begin
            c = 4'(codes[k]);
            reg_wr(pad_addr(1), {28'h0, c});
            m = fld(1, 1) | fld(9, 1) | fld(25, 1) | fld(33, 1);
            v = fld(1, c == 2) | fld(9, c == 0 || c == 2) | fld(25, c == 0) | fld(33, c == 2);
            expect_obs(m, v);
        end
        for (i = 0; i < 6; i++) begin
            rv = $random(seed);
            gpio_out <= rv[7:0];
            gpio_oe <= rv[15:8];
            pad_i[0] <= rv[16];
            tick(4);
            m = fld(8, 1) | fld(24, 1) | fld(0, rv[8]);
            expect_obs(m, fld(8, rv[8]) | fld(24, rv[16]) | fld(0, rv[0]));
        end
        gpio_oe <= 8'h00;
        reg_wr(pad_addr(7), {28'h0, PFS_FN_AUDIO});
        for (i = 0; i < 2; i++) begin
            audio_serial_data0 <= i[0];
            pad_i[7] <= 1'b1;
            m = fld(7, 1) | fld(15, 1) | fld(31, 1) | fld(39, 1);
            expect_obs(m, fld(7, i[0]) | fld(15, 1));
        end
        reg_wr(pad_addr(1), {26'h000_0000, PFS_LP_PULL, PFS_FN_GPIO});
        gpio_oe <= 8'hFF;
        gpio_out <= 8'hFF;
        for (md = 0; md < 2; md++) begin
            deep_sleep_state <= (md == 0);
            hibernate_state <= (md == 1);
            tick(3);
            for (lp = 0; lp < 4; lp++) begin
                reg_wr(pad_addr(0), 32'(lp << PFS_F_LP_LSB));
                m = fld(8, 1) | fld(0, lp >= 2) | fld(16, lp < 2) | fld(17, 1);
                v = fld(8, lp >= 2) | fld(0, lp == 3) | fld(16, lp == 1) | fld(17, 1);
                expect_obs(m, v);
            end
        end
        expect_obs(fld(14, 1) | fld(40, 1) | fld(41, 1), fld(40, 1));
        reg_rd(PFS_STAT_OFF, 32'h0000_0013);
        deep_sleep_state <= 1'b0;
        hibernate_state <= 1'b0;
        reg_wr(pad_addr(6), {28'h0, PFS_FN_GPIO});
        tick(3);
        m = fld(6, 1) | fld(14, 1) | fld(40, 1) | fld(41, 1);
        expect_obs(m, fld(6, 1) | fld(14, 1) | fld(41, 1));
        tick(2);
        tally_and_finish();
    end
endmodule
